// *** ssc_device.sv ***
// Device end: serial register bank, double buffering and fast-lock timing.
//
// Notes on behaviour
// - Shift 24 bits MSB first on clock rise.
// - Strobe rise copies word to selected register.
// - Select 000 writes the channel word.
// - Select 001 writes modulus and reference word.
// - Next phase-detector tick loads divider values.
// - Same tick starts fast lock, pump maximum.
// - Three filter switches close, open on timeouts.
// - Host needs only channel writes per hop.
// - Modulus, reference, phase settings wait for channel.
// - Host writes channel word top bit zero.
// - Integer field only 26 to 255.
// - Fraction feeds modulator, below the modulus.
// - Boost bit raises pump current 25 percent.
// - Half-rate bit halves phase-detector clock.
// - Host writes modulus word bit 21 zero.
// - Doubler bit doubles reference before divider.
// - Reference divider only 1 to 15.
// - Modulus only 13 to 4095.
// - Pump steps 64 down to 1 over six.
// - Timeout counters tick at quarter detector rate.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"
module ssc_device
	import ssc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ssc_link_if.device link,
	input wire logic reference_input,
	output logic [7:0] int_value,
	output logic [11:0] fraction_numerator,
	output logic [11:0] fraction_modulus,
	output logic [3:0] ref_divider,
	output logic half_rate,
	output logic doubler_on,
	output logic prescaler_sel,
	output logic pump_boost,
	output logic [11:0] phase_seed,
	output logic divider_load,
	output logic pfd_tick,
	output logic [6:0] pump_cells,
	output logic filter_switch_a,
	output logic filter_switch_b,
	output logic filter_switch_c,
	output logic fastlock_active,
	output logic [15:0] function_word,
	output logic [7:0] powerdown_word,
	output logic [15:0] output_select_word,
	output logic [15:0] test_word
);

	// ------------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------------
	logic [2:0] sclk_sy_q, le_sy_q, ref_sy_q;
	logic [1:0] sdat_sy_q;

	// The first stage of each chain is read only by the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_sy_q <= 3'h0;
			le_sy_q <= 3'h0;
			ref_sy_q <= 3'h0;
			sdat_sy_q <= 2'h0;
		end else begin
			sclk_sy_q <= {sclk_sy_q[1:0], link.sclk};
			le_sy_q <= {le_sy_q[1:0], link.load_strobe};
			ref_sy_q <= {ref_sy_q[1:0], reference_input};
			sdat_sy_q <= {sdat_sy_q[0], link.sdata};
		end
	end

	logic sclk_rise, le_rise, ref_rise, ref_fall;
	assign sclk_rise = sclk_sy_q[1] && !sclk_sy_q[2];
	assign le_rise = le_sy_q[1] && !le_sy_q[2];
	assign ref_rise = ref_sy_q[1] && !ref_sy_q[2];
	assign ref_fall = !ref_sy_q[1] && ref_sy_q[2];

	// ------------------------------------------------------------------------
	// Shift register and register decode
	// ------------------------------------------------------------------------
	logic [`SSC_WORD_W-1:0] shift_q;
	logic [2:0] sel;
	logic wr_chan, wr_modref;

	// Data and clock share one synchroniser depth, so the bit stays aligned.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
		end else if (sclk_rise) begin
			shift_q <= {shift_q[`SSC_WORD_W-2:0], sdat_sy_q[1]};
		end
	end

	assign sel = shift_q[`SSC_SEL_MSB:0];
	assign wr_chan = le_rise && (sel == `SSC_SEL_CHANNEL);
	assign wr_modref = le_rise && (sel == `SSC_SEL_MODREF);

	// Shadow copies of the buffered words, plus words used as written.
	logic [`SSC_WORD_W-1:0] chan_sh_q, modref_sh_q;
	logic [11:0] phase_sh_q;
	logic [8:0] to_pump_q, to_ab_q, to_c_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_sh_q <= '0;
			modref_sh_q <= '0;
			phase_sh_q <= 12'h000;
			function_word <= 16'h0000;
			powerdown_word <= 8'h00;
			output_select_word <= 16'h0000;
			test_word <= 16'h0000;
			to_pump_q <= 9'h000;
			to_ab_q <= 9'h000;
			to_c_q <= 9'h000;
		end else if (le_rise) begin
			case (sel)
				`SSC_SEL_CHANNEL: begin
					chan_sh_q <= shift_q;
				end
				`SSC_SEL_MODREF: begin
					modref_sh_q <= shift_q;
				end
				`SSC_SEL_PHASE: begin
					phase_sh_q <= shift_q[`SSC_PH_MSB:`SSC_PH_LSB];
				end
				`SSC_SEL_FUNCTION: begin
					function_word <= shift_q[15:0];
				end
				`SSC_SEL_TIMER: begin
					case (shift_q[`SSC_TM_SEL_MSB:`SSC_TM_SEL_LSB])
						`SSC_TM_SEL_PUMP: to_pump_q <= shift_q[`SSC_TM_CNT_MSB:`SSC_TM_CNT_LSB];
						`SSC_TM_SEL_SW_AB: to_ab_q <= shift_q[`SSC_TM_CNT_MSB:`SSC_TM_CNT_LSB];
						`SSC_TM_SEL_SW_C: to_c_q <= shift_q[`SSC_TM_CNT_MSB:`SSC_TM_CNT_LSB];
						default: begin
						end
					endcase
				end
				`SSC_SEL_POWERDOWN: begin
					powerdown_word <= shift_q[7:0];
				end
				`SSC_SEL_OUTSEL: begin
					output_select_word <= shift_q[15:0];
				end
				default: begin
					test_word <= shift_q[15:0];
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Applied settings
	// ------------------------------------------------------------------------
	// Buffered reference, modulus and phase settings go live when the channel
	// write completes; writes in between only touch the shadows.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fraction_modulus <= `SSC_MOD_RESET;
			ref_divider <= `SSC_RDIV_RESET;
			half_rate <= 1'b0;
			doubler_on <= 1'b0;
			prescaler_sel <= 1'b0;
			pump_boost <= 1'b0;
			phase_seed <= 12'h000;
		end else if (wr_chan) begin
			fraction_modulus <= modref_sh_q[`SSC_MR_MOD_MSB:`SSC_MR_MOD_LSB];
			ref_divider <= modref_sh_q[`SSC_MR_RDIV_MSB:`SSC_MR_RDIV_LSB];
			half_rate <= modref_sh_q[`SSC_MR_HALF_BIT];
			doubler_on <= modref_sh_q[`SSC_MR_DBL_BIT];
			prescaler_sel <= modref_sh_q[`SSC_MR_PRESC_BIT];
			pump_boost <= modref_sh_q[`SSC_MR_BOOST_BIT];
			phase_seed <= phase_sh_q;
		end
	end

	// ------------------------------------------------------------------------
	// Reference path: doubler, divider, half-rate stage, timer prescaler
	// ------------------------------------------------------------------------
	logic ref_tick, rdiv_tick, timer_tick;
	logic [3:0] rcnt_q;
	logic half_tgl_q;
	logic [1:0] pre_q;

	assign ref_tick = ref_rise || (doubler_on && ref_fall);
	assign rdiv_tick = ref_tick && (rcnt_q + 4'h1 >= ref_divider);
	assign pfd_tick = rdiv_tick && (!half_rate || half_tgl_q);
	assign timer_tick = pfd_tick && (pre_q == `SSC_TIMER_PRESCALE);

	// A zero divider acts as divide by one rather than stalling the loop.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rcnt_q <= 4'h0;
			half_tgl_q <= 1'b0;
			pre_q <= 2'h0;
		end else begin
			if (ref_tick) begin
				rcnt_q <= rdiv_tick ? 4'h0 : rcnt_q + 4'h1;
			end
			if (rdiv_tick) begin
				half_tgl_q <= !half_tgl_q;
			end
			if (pfd_tick) begin
				pre_q <= pre_q + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Divider update
	// ------------------------------------------------------------------------
	logic pending_q, apply;
	assign apply = pfd_tick && pending_q;

	// A new channel write in the applying cycle keeps the request alive.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= wr_chan || (pending_q && !pfd_tick);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_value <= `SSC_INT_RESET;
			fraction_numerator <= 12'h000;
			divider_load <= 1'b0;
		end else begin
			divider_load <= apply;
			if (apply) begin
				int_value <= chan_sh_q[`SSC_CH_INT_MSB:`SSC_CH_INT_LSB];
				fraction_numerator <= chan_sh_q[`SSC_CH_FRACTION_NUMERATOR_MSB:`SSC_CH_FRACTION_NUMERATOR_LSB];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Fast-lock timers
	// ------------------------------------------------------------------------
	logic [8:0] cnt_pump_q, cnt_ab_q, cnt_c_q;
	logic pump_hold_q;

	// Each timer counts down on the quarter-rate tick; expiry at one or zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_pump_q <= 9'h000;
			cnt_ab_q <= 9'h000;
			cnt_c_q <= 9'h000;
			pump_hold_q <= 1'b0;
			filter_switch_a <= 1'b0;
			filter_switch_b <= 1'b0;
			filter_switch_c <= 1'b0;
		end else if (apply) begin
			cnt_pump_q <= to_pump_q;
			cnt_ab_q <= to_ab_q;
			cnt_c_q <= to_c_q;
			pump_hold_q <= 1'b1;
			filter_switch_a <= 1'b1;
			filter_switch_b <= 1'b1;
			filter_switch_c <= 1'b1;
		end else if (timer_tick) begin
			if (cnt_pump_q != 9'h000) cnt_pump_q <= cnt_pump_q - 9'h001;
			if (cnt_ab_q != 9'h000) cnt_ab_q <= cnt_ab_q - 9'h001;
			if (cnt_c_q != 9'h000) cnt_c_q <= cnt_c_q - 9'h001;
			if (cnt_pump_q <= 9'h001) pump_hold_q <= 1'b0;
			if (cnt_ab_q <= 9'h001) begin
				filter_switch_a <= 1'b0;
				filter_switch_b <= 1'b0;
			end
			if (cnt_c_q <= 9'h001) filter_switch_c <= 1'b0;
		end
	end

	// Binary ramp: halve the active cells once per timer tick after expiry.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_cells <= `SSC_CELLS_MIN;
		end else if (apply) begin
			pump_cells <= `SSC_CELLS_MAX;
		end else if (timer_tick && !pump_hold_q && pump_cells > `SSC_CELLS_MIN) begin
			pump_cells <= {1'b0, pump_cells[6:1]};
		end
	end

	assign fastlock_active = pump_hold_q || (pump_cells != `SSC_CELLS_MIN)
		|| filter_switch_a || filter_switch_c;

endmodule
`default_nettype wire

// *** ssc_defs.svh ***
// Constants for the serial synthesizer control register bank.
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// ----------------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------------
`define SSC_WORD_W 24
`define SSC_SEL_MSB 2
`define SSC_SEL_CHANNEL 3'h0
`define SSC_SEL_MODREF 3'h1
`define SSC_SEL_PHASE 3'h2
`define SSC_SEL_FUNCTION 3'h3
`define SSC_SEL_TIMER 3'h4
`define SSC_SEL_POWERDOWN 3'h5
`define SSC_SEL_OUTSEL 3'h6
`define SSC_SEL_TEST 3'h7

// Channel word fields.
`define SSC_CH_RSVD_BIT 23
`define SSC_CH_INT_MSB 22
`define SSC_CH_INT_LSB 15
`define SSC_CH_FRACTION_NUMERATOR_MSB 14
`define SSC_CH_FRACTION_NUMERATOR_LSB 3

// Modulus and reference word fields.
`define SSC_MR_BOOST_BIT 23
`define SSC_MR_HALF_BIT 22
`define SSC_MR_RSVD_BIT 21
`define SSC_MR_PRESC_BIT 20
`define SSC_MR_DBL_BIT 19
`define SSC_MR_RDIV_MSB 18
`define SSC_MR_RDIV_LSB 15
`define SSC_MR_MOD_MSB 14
`define SSC_MR_MOD_LSB 3

// Phase word and fast-lock timer word fields.
`define SSC_PH_MSB 14
`define SSC_PH_LSB 3
`define SSC_TM_CNT_MSB 13
`define SSC_TM_CNT_LSB 5
`define SSC_TM_SEL_MSB 4
`define SSC_TM_SEL_LSB 3
`define SSC_TM_SEL_PUMP 2'h2
`define SSC_TM_SEL_SW_AB 2'h1
`define SSC_TM_SEL_SW_C 2'h0

// ----------------------------------------------------------------------------
// Legal ranges, reset values and timing
// ----------------------------------------------------------------------------
`define SSC_INT_MIN 8'h1A
`define SSC_RDIV_MIN 4'h1
`define SSC_MOD_MIN 12'h00D
`define SSC_MOD_RESET 12'hFFF
`define SSC_RDIV_RESET 4'h1
`define SSC_INT_RESET 8'h1A
`define SSC_CELLS_MAX 7'h40
`define SSC_CELLS_MIN 7'h01
`define SSC_TIMER_PRESCALE 2'h3
`define SSC_CLK_NS 50
`define SSC_SCLK_HALF_NS 200
`define SSC_SCLK_HALF_CYC ((`SSC_SCLK_HALF_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)

`endif

// *** ssc_pkg.sv ***
// Types shared by both ends of the serial synthesizer control link.
`default_nettype none
package ssc_pkg;

	// ------------------------------------------------------------------------
	// Host sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [4:0] {
		SSC_H_IDLE = 5'h01,
		SSC_H_LOW = 5'h02,
		SSC_H_HIGH = 5'h04,
		SSC_H_GAP = 5'h08,
		SSC_H_STROBE = 5'h10
	} ssc_host_state_t;

endpackage
`default_nettype wire

// *** ssc_link_if.sv ***
// Three-wire serial link between host and synthesizer control bank.
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if;
	logic sclk;
	logic sdata;
	logic load_strobe;

	modport host (
		output sclk,
		output sdata,
		output load_strobe
	);

	modport device (
		input sclk,
		input sdata,
		input load_strobe
	);
endinterface
`default_nettype wire

// *** ssc_host.sv ***
// Host end: checks user words and shifts them out over the three-wire link.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"
module ssc_host
	import ssc_pkg::*;
#(
	parameter int HALF_CYC = `SSC_SCLK_HALF_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	ssc_link_if.host link,
	input wire logic cmd_valid,
	input wire logic [`SSC_WORD_W-1:0] cmd_word,
	output logic cmd_ready,
	output logic cmd_refused,
	output logic busy
);

	// ------------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------------
	generate
		if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
			$error("HALF_CYC must lie in 1 to 255");
		end
	endgenerate

	ssc_host_state_t state_q;
	logic [7:0] half_q;
	logic [4:0] bit_q;
	logic [`SSC_WORD_W-1:0] shift_q;
	logic [11:0] mod_known_q;
	logic half_done;
	logic word_ok;
	logic [`SSC_WORD_W-1:0] word_fixed;
	logic [2:0] sel;
	logic take;

	assign sel = cmd_word[`SSC_SEL_MSB:0];
	assign half_done = (half_q == 8'(HALF_CYC - 1));
	assign cmd_ready = (state_q == SSC_H_IDLE);
	assign take = cmd_valid && cmd_ready;
	assign busy = !cmd_ready;

	// Range checks keep illegal divider values off the wire; a new channel
	// needs only a channel word, any other register may be rewritten at will.
	always_comb begin
		word_ok = 1'b1;
		word_fixed = cmd_word;
		if (sel == `SSC_SEL_CHANNEL) begin
			word_fixed[`SSC_CH_RSVD_BIT] = 1'b0;
			if (cmd_word[`SSC_CH_INT_MSB:`SSC_CH_INT_LSB] < `SSC_INT_MIN) begin
				word_ok = 1'b0;
			end
			if (cmd_word[`SSC_CH_FRACTION_NUMERATOR_MSB:`SSC_CH_FRACTION_NUMERATOR_LSB] >= mod_known_q) begin
				word_ok = 1'b0;
			end
		end else if (sel == `SSC_SEL_MODREF) begin
			word_fixed[`SSC_MR_RSVD_BIT] = 1'b0;
			if (cmd_word[`SSC_MR_RDIV_MSB:`SSC_MR_RDIV_LSB] < `SSC_RDIV_MIN) begin
				word_ok = 1'b0;
			end
			if (cmd_word[`SSC_MR_MOD_MSB:`SSC_MR_MOD_LSB] < `SSC_MOD_MIN) begin
				word_ok = 1'b0;
			end
		end
	end

	// Refusal pulse; the word is dropped and the host stays idle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= take && !word_ok;
		end
	end

	// Last accepted modulus, used to bound the fraction of later words.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_known_q <= `SSC_MOD_RESET;
		end else if (take && word_ok && sel == `SSC_SEL_MODREF) begin
			mod_known_q <= cmd_word[`SSC_MR_MOD_MSB:`SSC_MR_MOD_LSB];
		end
	end

	// Half-period timer of the serial clock divider.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_q <= 8'h00;
		end else if (state_q == SSC_H_IDLE || half_done) begin
			half_q <= 8'h00;
		end else begin
			half_q <= half_q + 8'h01;
		end
	end

	// Sequencer: data changes while the clock is low, MSB first, then the strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SSC_H_IDLE;
			shift_q <= '0;
			bit_q <= 5'h00;
		end else begin
			case (state_q)
				SSC_H_IDLE: begin
					if (take && word_ok) begin
						shift_q <= word_fixed;
						bit_q <= 5'(`SSC_WORD_W - 1);
						state_q <= SSC_H_LOW;
					end
				end
				SSC_H_LOW: begin
					if (half_done) begin
						state_q <= SSC_H_HIGH;
					end
				end
				SSC_H_HIGH: begin
					if (half_done) begin
						if (bit_q == 5'h00) begin
							state_q <= SSC_H_GAP;
						end else begin
							shift_q <= {shift_q[`SSC_WORD_W-2:0], 1'b0};
							bit_q <= bit_q - 5'h01;
							state_q <= SSC_H_LOW;
						end
					end
				end
				SSC_H_GAP: begin
					if (half_done) begin
						state_q <= SSC_H_STROBE;
					end
				end
				SSC_H_STROBE: begin
					if (half_done) begin
						state_q <= SSC_H_IDLE;
					end
				end
				default: begin
					state_q <= SSC_H_IDLE;
				end
			endcase
		end
	end

	// Registered pin drive.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.load_strobe <= 1'b0;
		end else begin
			link.sclk <= (state_q == SSC_H_HIGH);
			link.sdata <= shift_q[`SSC_WORD_W-1];
			link.load_strobe <= (state_q == SSC_H_STROBE);
		end
	end

endmodule
`default_nettype wire

// *** ssc_link_properties.sv ***
// Concurrent checks on the three-wire link between host and device ends.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"
module ssc_link_properties #(
	parameter int HALF_CYC = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe
);
	// ------------------------------------------------------------------------
	// Helper state
	// ------------------------------------------------------------------------
	logic sclk_q;
	logic [23:0] shift_q;
	logic [5:0] bits_q;
	logic [8:0] hi_q;
	logic [8:0] lo_q;
	logic [8:0] st_q;

	// Mirror of the receive shift register, so latched words can be judged.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			shift_q <= 24'h000000;
			bits_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (sclk && !sclk_q) begin
				shift_q <= {shift_q[22:0], sdata};
			end
			if (load_strobe) begin
				bits_q <= 6'h00;
			end else if (sclk && !sclk_q) begin
				bits_q <= bits_q + 6'h01;
			end
		end
	end

	// Run lengths of each level; the low count saturates because idle is long.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_q <= 9'h000;
			lo_q <= 9'h000;
			st_q <= 9'h000;
		end else begin
			hi_q <= sclk ? hi_q + 9'h001 : 9'h000;
			lo_q <= sclk ? 9'h000 : ((lo_q == 9'h1FF) ? lo_q : lo_q + 9'h001);
			st_q <= load_strobe ? st_q + 9'h001 : 9'h000;
		end
	end

	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_bit_rise;
		!sclk ##1 sclk;
	endsequence

	sequence s_latch;
		$rose(load_strobe);
	endsequence

	a_sclk_high_len: assert property ($fell(sclk) |-> hi_q == 9'(HALF_CYC))
		else $error("serial clock high phase has the wrong length");
	a_sclk_low_len: assert property ($rose(sclk) |-> lo_q >= 9'(HALF_CYC))
		else $error("serial clock low phase too short");
	a_data_stable: assert property (s_bit_rise |-> ($stable(sdata))[*4])
		else $error("serial data moved while the clock was high");
	a_frame_bits: assert property (s_latch |-> bits_q == 6'h18)
		else $error("frame did not carry 24 bits");
	a_strobe_len: assert property ($fell(load_strobe) |-> st_q == 9'(HALF_CYC))
		else $error("load strobe has the wrong length");
	a_strobe_quiet: assert property (load_strobe |-> !sclk && lo_q >= 9'(HALF_CYC))
		else $error("load strobe overlaps serial clock activity");
	a_chan_top_zero: assert property (s_latch ##0 shift_q[2:0] == 3'h0 |-> !shift_q[23])
		else $error("channel word sent with top bit set");
	a_chan_int_range: assert property (s_latch ##0 shift_q[2:0] == 3'h0 |->
		shift_q[22:15] >= `SSC_INT_MIN)
		else $error("channel word sent with integer below minimum");
	a_modref_bit_zero: assert property (s_latch ##0 shift_q[2:0] == 3'h1 |-> !shift_q[21])
		else $error("modulus word sent with reserved bit set");
	a_modref_rdiv: assert property (s_latch ##0 shift_q[2:0] == 3'h1 |-> shift_q[18:15] != 4'h0)
		else $error("modulus word sent with zero reference divider");
	a_modref_mod: assert property (s_latch ##0 shift_q[2:0] == 3'h1 |->
		shift_q[14:3] >= `SSC_MOD_MIN)
		else $error("modulus word sent with modulus below minimum");
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"
module testbench;
	// ------------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n;
	logic cmd_valid;
	logic [23:0] cmd_word;
	logic cmd_ready, cmd_refused, busy;
	logic reference_input = 1'b0;
	logic [7:0] int_value, powerdown_word;
	logic [11:0] fraction_numerator, fraction_modulus, phase_seed;
	logic [3:0] ref_divider;
	logic half_rate, doubler_on, prescaler_sel, pump_boost, divider_load, pfd_tick;
	logic [6:0] pump_cells;
	logic filter_switch_a, filter_switch_b, filter_switch_c, fastlock_active;
	logic [15:0] function_word, output_select_word, test_word;
	int n_fail = 0;
	int cmp_count = 0;
	int dl_cnt = 0;

	ssc_link_if link();
	ssc_host #(.HALF_CYC(4)) u_ssc_host (.clk, .rst_n, .link(link), .cmd_valid, .cmd_word,
		.cmd_ready, .cmd_refused, .busy);
	ssc_device u_ssc_device (.clk, .rst_n, .link(link), .reference_input, .int_value,
		.fraction_numerator, .fraction_modulus, .ref_divider, .half_rate, .doubler_on,
		.prescaler_sel, .pump_boost, .phase_seed, .divider_load, .pfd_tick, .pump_cells,
		.filter_switch_a, .filter_switch_b, .filter_switch_c, .fastlock_active,
		.function_word, .powerdown_word, .output_select_word, .test_word);
	ssc_link_properties #(.HALF_CYC(4)) u_ssc_link_properties (.clk, .rst_n,
		.sclk(link.sclk), .sdata(link.sdata), .load_strobe(link.load_strobe));

	// Clock at 20 MHz; the reference edges land on falling clock edges.
	always #25 clk = ~clk;
	always #200 reference_input = ~reference_input;

	// Divider reloads are pulses, so they are counted rather than polled.
	always @(negedge clk) begin
		if (divider_load === 1'b1) begin
			dl_cnt++;
		end
	end

	// ------------------------------------------------------------------------
	// Common tasks
	// ------------------------------------------------------------------------
	task automatic test_done();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic hang();
		n_fail++;
		test_done();
	endtask

	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Issue one word; the refusal pulse is caught in either of the next two cycles.
	task automatic send(input logic [23:0] w, input logic exp_ref);
		int i;
		logic seen;
		seen = 1'b0;
		for (i = 0; i < 500 && cmd_ready !== 1'b1; i++) @(negedge clk);
		if (i == 500) hang();
		cmd_valid = 1'b1;
		cmd_word = w;
		@(negedge clk);
		cmd_valid = 1'b0;
		seen = (cmd_refused === 1'b1);
		@(negedge clk);
		seen = seen | (cmd_refused === 1'b1);
		chk_val(24'(seen), 24'(exp_ref));
		for (i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk);
		if (i == 500) hang();
	endtask

	// A channel write, returning once the divider has reloaded.
	task automatic hop(input logic [23:0] w);
		int i;
		int c0;
		c0 = dl_cnt;
		send(w, 1'b0);
		for (i = 0; i < 500 && dl_cnt == c0; i++) @(negedge clk);
		if (i == 500) hang();
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_reset();
		chk_val(24'(int_value), 24'h00001A);
		chk_val(24'(fraction_numerator), 24'h000000);
		chk_val(24'(fraction_modulus), 24'h000FFF);
		chk_val(24'(ref_divider), 24'h000001);
		chk_val(24'(pump_cells), 24'h000001);
		chk_val(24'({filter_switch_a, filter_switch_b, filter_switch_c}), 24'h0);
	endtask

	task automatic t_regs();
		send(24'h000143, 1'b0);
		chk_val(24'(function_word), 24'h000143);
		send(24'h0000AD, 1'b0);
		chk_val(24'(powerdown_word), 24'h0000AD);
		send(24'h003456, 1'b0);
		chk_val(24'(output_select_word), 24'h003456);
		send(24'h000007, 1'b0);
		chk_val(24'(test_word), 24'h000007);
	endtask

	// Settings written ahead of a channel word must wait for it.
	task automatic t_shadow();
		send(24'h004054, 1'b0);
		send(24'h00408C, 1'b0);
		send(24'h0040A4, 1'b0);
		send(24'hC98321, 1'b0);
		send(24'h00091A, 1'b0);
		chk_val(24'(fraction_modulus), 24'h000FFF);
		chk_val(24'({ref_divider, half_rate, doubler_on, pump_boost}), 24'h8);
		chk_val(24'(phase_seed), 24'h000000);
		hop(24'h0F0190);
		chk_val(24'(fraction_modulus), 24'h000064);
		chk_val(24'({ref_divider, half_rate, doubler_on, pump_boost}), 24'h1F);
		chk_val(24'({prescaler_sel, phase_seed}), 24'h000123);
		chk_val(24'(int_value), 24'h00001E);
		chk_val(24'(fraction_numerator), 24'h000032);
		chk_val(24'({fastlock_active, pump_cells}), 24'h0000C0);
		chk_val(24'({filter_switch_a, filter_switch_b, filter_switch_c}), 24'h7);
	endtask

	// Timer ticks come every 96 clocks with doubler, divide by 3 and half rate.
	task automatic t_fastlock();
		int i;
		logic [6:0] prev;
		for (i = 0; i < 1000 && pump_cells !== 7'h20; i++) @(negedge clk);
		if (i == 1000) hang();
		for (int k = 0; k < 5; k++) begin
			prev = pump_cells;
			for (i = 0; i < 200 && pump_cells === prev; i++) @(negedge clk);
			chk_val(24'(i), 24'h000060);
			chk_val(24'(pump_cells), 24'(7'h10 >> k));
			if (k == 0) begin
				chk_val(24'({filter_switch_a, filter_switch_b, filter_switch_c}), 24'h1);
			end
			if (k == 1) begin
				chk_val(24'({filter_switch_a, filter_switch_b, filter_switch_c}), 24'h0);
			end
		end
		repeat (2) @(negedge clk);
		chk_val(24'(fastlock_active), 24'h000000);
	endtask

	// Out-of-range words are refused; boundary words and forced zero bits pass.
	task automatic t_refuse();
		send(24'h0C8000, 1'b1);
		send(24'h000321, 1'b1);
		send(24'h008061, 1'b1);
		send(24'h0F0320, 1'b1);
		repeat (100) @(negedge clk);
		chk_val(24'({int_value, fraction_modulus}), 24'h1E064);
		send(24'h378069, 1'b0);
		hop(24'hFF8060);
		chk_val(24'({int_value, fraction_numerator}), 24'hFF00C);
		chk_val(24'({ref_divider, fraction_modulus}), 24'hF00D);
		chk_val(24'({half_rate, doubler_on, pump_boost}), 24'h0);
		chk_val(24'(prescaler_sel), 24'h000001);
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_word = 24'h000000;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_regs();
		t_shadow();
		t_fastlock();
		t_refuse();
		test_done();
	end
endmodule
`default_nettype wire
